// File: common/prc_map.svh
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// ******************************
// register offsets
// ******************************
`define PRC_ADDR_PCC   8'h0C
`define PRC_ADDR_PRC   8'h0D
`define PRC_ADDR_LRC   8'h0E
`define PRC_ADDR_PIC   8'h0F
`define PRC_ADDR_GDV   8'h10
// ******************************
// reset values, strap bits low
// ******************************
`define PRC_RST_PCC    8'h32
`define PRC_RST_PRC    8'h60
`define PRC_RST_LRC    8'h88
`define PRC_RST_PIC    8'h00
`define PRC_RST_GDV    8'h00
`define PRC_RST_NONE   8'h00
// ******************************
// peripheral converter fields
// ******************************
`define PRC_PCC_FFF    7
`define PRC_PCC_UV_HI  6
`define PRC_PCC_UV_LO  5
`define PRC_PCC_SUP    4
`define PRC_PCC_LPEN   3
`define PRC_PCC_MDIS   2
`define PRC_PCC_MV_HI  1
`define PRC_PCC_MV_LO  0
// ******************************
// processor converter fields
// ******************************
`define PRC_PRC_OFF    7
`define PRC_PRC_CV_HI  6
`define PRC_PRC_CV_LO  4
`define PRC_PRC_LP_HI  3
`define PRC_PRC_LP_LO  2
`define PRC_PRC_VIB    1
`define PRC_PRC_CDIS   0
// ******************************
// linear regulator fields
// ******************************
`define PRC_LRC_L2EN   7
`define PRC_LRC_L2SO   6
`define PRC_LRC_L2_HI  5
`define PRC_LRC_L2_LO  4
`define PRC_LRC_L1EN   3
`define PRC_LRC_L1SO   2
`define PRC_LRC_L1_HI  1
`define PRC_LRC_L1_LO  0
// ******************************
// pin fields and strap timing
// ******************************
`define PRC_PIC_EDGE   4
`define PRC_PIC_MASK   0
`define PRC_GDV_DIR    4
`define PRC_GDV_VAL    0
`define PRC_STRAP_WAIT 2'h2
`endif

// File: common/prc_pkg.sv
package prc_pkg;
  // ******************************
  // whole state of the bank
  // ******************************
  typedef struct packed {
    logic [7:0] pcc;
    logic [7:0] prc;
    logic [7:0] lrc;
    logic [7:0] pic;
    logic [3:0] gdir;
    logic [3:0] gval;
    logic       lp_s1;
    logic       lp_s2;
    logic       pm_s1;
    logic       pm_s2;
    logic       pc_s1;
    logic       pc_s2;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_d;
    logic [3:0] pend;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic [7:0] rdata;
    logic       rvalid;
    logic       fff;
    logic [1:0] uv_sel;
    logic [1:0] prail_sel;
    logic       prail_on;
    logic       prail_dis;
    logic [2:0] crail_sel;
    logic       crail_on;
    logic       crail_dis;
    logic       vibrator_driver_on;
    logic       wait_mode;
    logic       low_power;
    logic       l1_on;
    logic       l1_red;
    logic [1:0] l1_sel;
    logic       l2_on;
    logic       l2_red;
    logic [1:0] l2_sel;
    logic [3:0] pin_oe_n;
    logic       irq;
  } prc_state_t;
endpackage : prc_pkg

// File: src/prc_regs.sv
`timescale 1ns/1ps
`include "prc_map.svh"
// Notes on behaviour
// - forced-fixed-frequency bit 1 keeps both converters in fixed PWM.
// - two-bit undervoltage threshold selects 2.5 to 3.25 V, default 01.
// - active low-power request enters wait or low power by supply select.
// - low-power pin enable 0 makes the request pin ignored.
// - peripheral discharge bit discharges the rail while it is off.
// - peripheral voltage field, low bit from strap, host may overwrite.
// - processor voltage field default from strap, 60h or 70h.
// - off-in-low-power bit disables processor rail in low power.
// - three-bit processor voltage code, host may overwrite.
// - low power uses code 0 plus low-power bits, normal code after.
// - vibrator bit drives the vibrator transistor on.
// - processor discharge in wait, or low power when rail is off.
// - regulator enable, full power normal, sleep-off bit in low power.
// - regulator voltage changes only while disabled; default 88h.
// - second regulator voltage codes 1.8 to 3.3 V, default 00.
// - first regulator default 00 is external divider setting.
// - edge bit picks falling or rising edge for input pin events.
// - mask bit 1 suppresses a pin event; masks reset to 0.
// - direction bit 0 input, 1 output; all reset to input.
// - output value 1 pulls pin low, 0 releases it.
// - input pins read their level; writes to those bits ignored.
module prc_regs
  import prc_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  // register port from serial interface
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  output logic            rvalid_out,
  // pins
  input  wire logic       low_power_request_pin_in,
  input  wire logic       peripheral_rail_strap_in,
  input  wire logic       processor_rail_strap_in,
  input  wire logic [3:0] pin_level_in,
  output logic      [3:0] pin_drive_out,
  output logic      [3:0] pin_oe_n_out,
  // pin event service
  input  wire logic [3:0] pin_irq_ack_in,
  output logic      [3:0] pin_irq_pending_out,
  output logic            pin_irq_out,
  // converter controls
  output logic            forced_fixed_frequency_out,
  output logic      [1:0] undervoltage_threshold_sel_out,
  output logic      [1:0] peripheral_rail_sel_out,
  output logic            peripheral_rail_on_out,
  output logic            peripheral_rail_discharge_out,
  output logic      [2:0] processor_rail_sel_out,
  output logic            processor_rail_on_out,
  output logic            processor_rail_discharge_out,
  output logic            vibrator_driver_on_out,
  output logic            wait_mode_out,
  output logic            low_power_mode_out,
  // regulator controls
  output logic            first_linear_regulator_on_out,
  output logic            first_linear_regulator_reduced_out,
  output logic      [1:0] first_regulator_voltage_sel_out,
  output logic            second_linear_regulator_on_out,
  output logic            second_linear_regulator_reduced_out,
  output logic      [1:0] second_regulator_voltage_sel_out
);

  // ******************************
  // reset state
  // ******************************
  localparam prc_state_t PRC_RESET = '{
    pcc:       `PRC_RST_PCC,
    prc:       `PRC_RST_PRC,
    lrc:       `PRC_RST_LRC,
    pic:       `PRC_RST_PIC,
    gdir:      4'h0,
    gval:      4'h0,
    uv_sel:    2'h1,
    prail_sel: 2'h2,
    prail_on:  1'b1,
    crail_sel: 3'h6,
    crail_on:  1'b1,
    l1_on:     1'b1,
    l2_on:     1'b1,
    pin_oe_n:  4'hF,
    default:   '0
  };

  prc_state_t s_reg;
  prc_state_t s_next;

  // ******************************
  // read decode
  // ******************************
  function automatic logic [7:0] prc_read(
    input logic [7:0] addr,
    input prc_state_t s
  );
    logic [3:0] vals;
    vals = (s.gdir & s.gval) | (~s.gdir & s.pin_s2);
    case (addr)
      `PRC_ADDR_PCC: prc_read = s.pcc;
      `PRC_ADDR_PRC: prc_read = s.prc;
      `PRC_ADDR_LRC: prc_read = s.lrc;
      `PRC_ADDR_PIC: prc_read = s.pic;
      `PRC_ADDR_GDV: prc_read = {s.gdir, vals};
      default:       prc_read = `PRC_RST_NONE;
    endcase
  endfunction : prc_read

  // ******************************
  // next state
  // ******************************
  always_comb begin
    logic       lp_act;
    logic       edge_hit;
    logic [3:0] dir_new;
    lp_act   = 1'b0;
    edge_hit = 1'b0;
    dir_new  = 4'h0;
    s_next   = s_reg;

    s_next.lp_s1  = low_power_request_pin_in;
    s_next.lp_s2  = s_reg.lp_s1;
    s_next.pm_s1  = peripheral_rail_strap_in;
    s_next.pm_s2  = s_reg.pm_s1;
    s_next.pc_s1  = processor_rail_strap_in;
    s_next.pc_s2  = s_reg.pc_s1;
    s_next.pin_s1 = pin_level_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_d  = s_reg.pin_s2;

    if (!s_reg.strap_done) begin
      s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      if (s_reg.strap_cnt == `PRC_STRAP_WAIT) begin
        s_next.pcc[`PRC_PCC_MV_LO] = s_reg.pm_s2;
        s_next.prc[`PRC_PRC_CV_LO] = s_reg.pc_s2;
        s_next.strap_done          = 1'b1;
      end
    end else if (wr_en_in) begin
      case (addr_in)
        `PRC_ADDR_PCC: s_next.pcc = wdata_in;
        `PRC_ADDR_PRC: s_next.prc = wdata_in;
        `PRC_ADDR_LRC: begin
          s_next.lrc[`PRC_LRC_L2EN] = wdata_in[`PRC_LRC_L2EN];
          s_next.lrc[`PRC_LRC_L2SO] = wdata_in[`PRC_LRC_L2SO];
          s_next.lrc[`PRC_LRC_L1EN] = wdata_in[`PRC_LRC_L1EN];
          s_next.lrc[`PRC_LRC_L1SO] = wdata_in[`PRC_LRC_L1SO];
          if (!s_reg.lrc[`PRC_LRC_L2EN]) begin
            s_next.lrc[`PRC_LRC_L2_HI:`PRC_LRC_L2_LO] =
              wdata_in[`PRC_LRC_L2_HI:`PRC_LRC_L2_LO];
          end
          if (!s_reg.lrc[`PRC_LRC_L1EN]) begin
            s_next.lrc[`PRC_LRC_L1_HI:`PRC_LRC_L1_LO] =
              wdata_in[`PRC_LRC_L1_HI:`PRC_LRC_L1_LO];
          end
        end
        `PRC_ADDR_PIC: s_next.pic = wdata_in;
        `PRC_ADDR_GDV: begin
          dir_new     = wdata_in[`PRC_GDV_DIR +: 4];
          s_next.gdir = dir_new;
          s_next.gval = (dir_new & wdata_in[`PRC_GDV_VAL +: 4])
                      | (~dir_new & s_reg.gval);
        end
        default: s_next.pcc = s_reg.pcc;
      endcase
    end

    // edge events, set wins over ack
    for (int i = 0; i < 4; i++) begin
      edge_hit = s_reg.pic[`PRC_PIC_EDGE + i]
               ? (s_reg.pin_s2[i] & ~s_reg.pin_d[i])
               : (~s_reg.pin_s2[i] & s_reg.pin_d[i]);
      edge_hit = edge_hit & ~s_reg.gdir[i]
               & ~s_reg.pic[`PRC_PIC_MASK + i];
      s_next.pend[i] = edge_hit
                     | (s_reg.pend[i] & ~pin_irq_ack_in[i]);
    end
    s_next.irq = |s_next.pend;

    // read answer one cycle later
    s_next.rvalid = rd_en_in;
    if (rd_en_in) begin
      s_next.rdata = prc_read(addr_in, s_reg);
    end

    lp_act = s_next.lp_s2 & s_next.pcc[`PRC_PCC_LPEN];
    // wait or low power by supply select
    s_next.wait_mode = lp_act & ~s_next.pcc[`PRC_PCC_SUP];
    s_next.low_power = lp_act & s_next.pcc[`PRC_PCC_SUP];

    s_next.fff = s_next.pcc[`PRC_PCC_FFF];
    s_next.uv_sel = s_next.pcc[`PRC_PCC_UV_HI:`PRC_PCC_UV_LO];
    s_next.prail_sel = s_next.pcc[`PRC_PCC_MV_HI:`PRC_PCC_MV_LO];
    s_next.prail_on  = ~s_next.wait_mode;
    s_next.prail_dis = s_next.pcc[`PRC_PCC_MDIS] & s_next.wait_mode;

    // processor rail off in wait, or in low power when the off bit is set
    s_next.crail_on = ~s_next.wait_mode
      & ~(s_next.low_power & s_next.prc[`PRC_PRC_OFF]);
    if (s_next.low_power) begin
      s_next.crail_sel =
        {1'b0, s_next.prc[`PRC_PRC_LP_HI:`PRC_PRC_LP_LO]};
    end else begin
      s_next.crail_sel = s_next.prc[`PRC_PRC_CV_HI:`PRC_PRC_CV_LO];
    end
    s_next.crail_dis = s_next.prc[`PRC_PRC_CDIS]
      & (s_next.wait_mode
         | (s_next.low_power & s_next.prc[`PRC_PRC_OFF]));
    s_next.vibrator_driver_on = s_next.prc[`PRC_PRC_VIB];

    s_next.l1_on  = s_next.lrc[`PRC_LRC_L1EN]
      & ~(s_next.low_power & s_next.lrc[`PRC_LRC_L1SO]);
    s_next.l1_red = s_next.lrc[`PRC_LRC_L1EN] & s_next.low_power
      & ~s_next.lrc[`PRC_LRC_L1SO];
    s_next.l2_on  = s_next.lrc[`PRC_LRC_L2EN]
      & ~(s_next.low_power & s_next.lrc[`PRC_LRC_L2SO]);
    s_next.l2_red = s_next.lrc[`PRC_LRC_L2EN] & s_next.low_power
      & ~s_next.lrc[`PRC_LRC_L2SO];
    s_next.l1_sel = s_next.lrc[`PRC_LRC_L1_HI:`PRC_LRC_L1_LO];
    s_next.l2_sel = s_next.lrc[`PRC_LRC_L2_HI:`PRC_LRC_L2_LO];

    s_next.pin_oe_n = ~(s_next.gdir & s_next.gval);
  end

  // ******************************
  // state register
  // ******************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_reg <= PRC_RESET;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign rdata_out                      = s_reg.rdata;
  assign rvalid_out                     = s_reg.rvalid;
  assign pin_drive_out                  = 4'h0;
  assign pin_oe_n_out                   = s_reg.pin_oe_n;
  assign pin_irq_pending_out            = s_reg.pend;
  assign pin_irq_out                    = s_reg.irq;
  assign forced_fixed_frequency_out     = s_reg.fff;
  assign undervoltage_threshold_sel_out = s_reg.uv_sel;
  assign peripheral_rail_sel_out        = s_reg.prail_sel;
  assign peripheral_rail_on_out         = s_reg.prail_on;
  assign peripheral_rail_discharge_out  = s_reg.prail_dis;
  assign processor_rail_sel_out         = s_reg.crail_sel;
  assign processor_rail_on_out          = s_reg.crail_on;
  assign processor_rail_discharge_out   = s_reg.crail_dis;
  assign vibrator_driver_on_out         = s_reg.vibrator_driver_on;
  assign wait_mode_out                  = s_reg.wait_mode;
  assign low_power_mode_out             = s_reg.low_power;
  assign first_linear_regulator_on_out  = s_reg.l1_on;
  assign first_linear_regulator_reduced_out  = s_reg.l1_red;
  assign first_regulator_voltage_sel_out     = s_reg.l1_sel;
  assign second_linear_regulator_on_out      = s_reg.l2_on;
  assign second_linear_regulator_reduced_out = s_reg.l2_red;
  assign second_regulator_voltage_sel_out    = s_reg.l2_sel;

  // ******************************
  // checks
  // ******************************
  a_fff_write: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && wr_en_in && s_reg.strap_done
     && addr_in == `PRC_ADDR_PCC)
    |=> forced_fixed_frequency_out == $past(wdata_in[`PRC_PCC_FFF]))
    else $error("fixed frequency output missed write");

  a_uv_write: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && wr_en_in && s_reg.strap_done
     && addr_in == `PRC_ADDR_PCC)
    |=> undervoltage_threshold_sel_out
        == $past(wdata_in[`PRC_PCC_UV_HI:`PRC_PCC_UV_LO]))
    else $error("threshold output missed write");

  a_mode_excl: assert property (
    @(posedge clk_in) disable iff (reset_in)
    !(wait_mode_out && low_power_mode_out)
    && (peripheral_rail_on_out == !wait_mode_out))
    else $error("wait and low power overlap");

  a_lp_gate: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (wait_mode_out || low_power_mode_out)
    |-> s_reg.pcc[`PRC_PCC_LPEN] && s_reg.lp_s2)
    else $error("low power mode without enable");

  a_lp_code: assert property (
    @(posedge clk_in) disable iff (reset_in)
    low_power_mode_out |-> processor_rail_sel_out
      == {1'b0, s_reg.prc[`PRC_PRC_LP_HI:`PRC_PRC_LP_LO]})
    else $error("low power code wrong");

  a_core_dis: assert property (
    @(posedge clk_in) disable iff (reset_in)
    processor_rail_discharge_out
    |-> !processor_rail_on_out && s_reg.prc[`PRC_PRC_CDIS])
    else $error("discharge while rail on");

  a_ldo_sleep: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (low_power_mode_out && s_reg.lrc[`PRC_LRC_L1SO])
    |-> !first_linear_regulator_on_out)
    else $error("regulator on in low power");

  a_mask_event: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (s_reg.pend[0] && !$past(s_reg.pend[0]))
    |-> !$past(s_reg.pic[`PRC_PIC_MASK]))
    else $error("masked pin raised event");

  a_input_ign: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (ce_in && wr_en_in && s_reg.strap_done && !wdata_in[`PRC_GDV_DIR]
     && addr_in == `PRC_ADDR_GDV)
    |=> s_reg.gval[0] == $past(s_reg.gval[0]))
    else $error("input value bit was written");

  a_strap_load: assert property (
    @(posedge clk_in) disable iff (reset_in)
    $rose(s_reg.strap_done)
    |-> s_reg.prc[`PRC_PRC_CV_LO] == $past(s_reg.pc_s2))
    else $error("strap not loaded");

endmodule : prc_regs

// File: dv/prc_host_model.sv
`timescale 1ns/1ps
module prc_host_model (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic            wr_en_out,
  output logic            rd_en_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en_out = 1'b1;
    addr_out  = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask : write_reg
  // released bus shows inverted values
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge clk_in);
    rd_en_out = 1'b1;
    addr_out  = a;
    @(negedge clk_in);
    rd_en_out = 1'b0;
    addr_out  = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d  = rdata_in;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask : read_reg
endmodule : prc_host_model

// File: dv/pmic_rail_and_gpio_control_regs_bench.sv
`timescale 1ns/1ps
`include "prc_map.svh"
module pmic_rail_and_gpio_control_regs_bench;
  logic       clk_in, reset_in, ce_in, lp_pin, sp, sc;
  logic       wr_en, rd_en, rvalid, irq, fff, pon, pdis, con, cdis, vibrator_driver_on;
  logic       wt, lp, l1on, l1red, l2on, l2red;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] pin_ext, ack, drive, oe_n, pend, lvl;
  logic [1:0] uv, psel, l1sel, l2sel;
  logic [2:0] csel;
  int         fail_count, checks, mr[5], la[5];
  // open-drain pins with pull-up
  assign lvl = pin_ext & oe_n;
  prc_host_model i_prc_host_model (.clk_in(clk_in), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata),
    .rdata_in(rdata), .rvalid_in(rvalid));
  prc_regs i_prc_regs (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
    .rdata_out(rdata), .rvalid_out(rvalid),
    .low_power_request_pin_in(lp_pin), .peripheral_rail_strap_in(sp),
    .processor_rail_strap_in(sc), .pin_level_in(lvl),
    .pin_drive_out(drive), .pin_oe_n_out(oe_n), .pin_irq_ack_in(ack),
    .pin_irq_pending_out(pend), .pin_irq_out(irq),
    .forced_fixed_frequency_out(fff), .undervoltage_threshold_sel_out(uv),
    .peripheral_rail_sel_out(psel), .peripheral_rail_on_out(pon),
    .peripheral_rail_discharge_out(pdis), .processor_rail_sel_out(csel),
    .processor_rail_on_out(con), .processor_rail_discharge_out(cdis),
    .vibrator_driver_on_out(vibrator_driver_on), .wait_mode_out(wt),
    .low_power_mode_out(lp), .first_linear_regulator_on_out(l1on),
    .first_linear_regulator_reduced_out(l1red),
    .first_regulator_voltage_sel_out(l1sel),
    .second_linear_regulator_on_out(l2on),
    .second_linear_regulator_reduced_out(l2red),
    .second_regulator_voltage_sel_out(l2sel));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // ******************************
  // checking helpers
  // ******************************
  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  function automatic int mread(input int a);
    if (a < 12 || a > 16) return 0;
    if (a == 16) return (mr[4] & 'hF0) | (mr[4] & (mr[4] >> 4) & 'hF)
                        | (lvl & ~(mr[4] >> 4) & 'hF);
    return mr[a - 12];
  endfunction : mread
  task automatic wr(input int a, input int v);
    i_prc_host_model.write_reg(8'(a), 8'(v));
    if (a == 14 && mr[2][7]) v = (v & 'hCF) | (mr[2] & 'h30);
    if (a == 14 && mr[2][3]) v = (v & 'hFC) | (mr[2] & 'h03);
    if (a == 16) v = (v & 'hF0) | (v & (v >> 4) & 'hF);
    if (a >= 12 && a <= 16) mr[a - 12] = v & 'hFF;
  endtask : wr
  task automatic rd_chk(input int a);
    logic [7:0] g;
    logic       ok;
    i_prc_host_model.read_reg(8'(a), g, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      finish_test;
    end else begin
      chk(16'(g), 16'(mread(a)));
    end
  endtask : rd_chk
  task automatic ack_pulse(input logic [3:0] m);
    ack = m;
    cyc(1);
    ack = 4'h0;
  endtask : ack_pulse
  task automatic mode_chk(input logic s, e, p, o);
    logic w, l, c;
    w = p & e & ~s;
    l = p & e & s;
    c = ~(w | (l & o));
    chk(16'({wt, lp, pon, pdis, con, cdis, csel, l1on, l1red, l2on, l2red}),
        16'({w, l, ~w, w, c, ~c, l ? 3'h1 : 3'h5, ~(l & ~o), l & o,
             ~(l & o), l & ~o}));
  endtask : mode_chk
  // ******************************
  // main sequence
  // ******************************
  initial begin
    void'($urandom(32'h28C7));
    fail_count = 0;
    checks = 0;
    reset_in = 1'b1;
    ce_in = 1'b1;
    lp_pin = 1'b0;
    pin_ext = 4'hF;
    ack = 4'h0;
    sp = 1'($urandom % 2);
    sc = 1'($urandom % 2);
    mr = '{'h32 | sp, 'h60 | (sc << 4), 'h88, 0, 0};
    la = '{11, 12, 13, 14, 17};
    cyc(10);
    reset_in = 1'b0;
    cyc(6);
    for (int a = 11; a <= 17; a++) rd_chk(a);
    foreach (la[i]) begin
      wr(la[i], (i == 2) ? 'hBB : 0);
      rd_chk(la[i]);
    end
    for (int i = 0; i < 30; i++) begin
      wr(la[i % 5], $urandom % 256);
      rd_chk(la[i % 5]);
      chk(16'({fff, uv, psel, vibrator_driver_on, csel, l1on, l1sel, l2on, l2sel}),
          16'({mr[0][7], mr[0][6:5], mr[0][1:0], mr[1][1], mr[1][6:4],
               mr[2][3], mr[2][1:0], mr[2][7], mr[2][5:4]}));
    end
    for (int k = 0; k < 16; k++) begin
      wr(12, 'h26 | (k[0] << 4) | (k[1] << 3));
      wr(13, 'h55 | (k[3] << 7));
      wr(14, 'h88 | (k[3] << 6) | (!k[3] << 2));
      lp_pin = k[2];
      cyc(6);
      mode_chk(k[0], k[1], k[2], k[3]);
      lp_pin = 1'b0;
      cyc(6);
      mode_chk(k[0], k[1], 1'b0, k[3]);
    end
    ce_in = 1'b0;
    i_prc_host_model.write_reg(8'h0C, 8'hFF);
    ce_in = 1'b1;
    rd_chk(12);
    wr(15, 'h0F);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(16, d);
      pin_ext = 4'($urandom);
      cyc(5);
      rd_chk(16);
      chk(16'(oe_n), {12'h0, ~(d[7:4] & d[3:0])});
      chk(16'(drive), 16'h0);
    end
    for (int p = 0; p < 4; p++) begin
      for (int q = 0; q < 4; q++) begin
        wr(16, 0);
        wr(15, (q[0] << (p + 4)) | (q[1] << p));
        pin_ext[p] = ~q[0];
        cyc(6);
        ack_pulse(4'hF);
        cyc(2);
        pin_ext[p] = q[0];
        cyc(6);
        chk(16'({pend, irq}), q[1] ? 16'h0 : 16'({4'(1 << p), 1'b1}));
        ack_pulse(4'(1 << p));
        cyc(2);
        chk(16'({pend, irq}), 16'h0);
        pin_ext[p] = ~q[0];
        cyc(6);
        chk(16'({pend, irq}), 16'h0);
      end
    end
    pin_ext = 4'hF;
    wr(15, 0);
    wr(16, 'hF0);
    ack_pulse(4'hF);
    cyc(2);
    pin_ext = 4'h0;
    cyc(6);
    chk(16'({pend, irq}), 16'h0);
    finish_test;
  end
endmodule : pmic_rail_and_gpio_control_regs_bench
